// file: design/hlsc_device.sv
// bridge device end: link speed and width configuration registers and the active link setup
// Summary of operation
// [R1] power-up runs 200 MHz, 8 bits
// [R2] new settings apply only after warm reset
// [R3] index: write-enable bit 8, index 6:0
// [R4] index at 0x94, data at 0x98
// [R5] read-only capability bitmap in D0 31:16
// [R6] frequency code field in D0 11:8
// [R7] codes map to frequencies and generations
// [R8] ten-bit bias field in D8 9:0
// [R9] receive width in C8 26:24
// [R10] transmit width in C8 30:28
// [R11] drive strength at indirect 0x2A 1:0
// [R12] both ends share one frequency code; not enforced, a differing code only raises freq_mismatch at the processor end
// [R13] device stays unit 0, no tunnel
// [R14] programmed fields survive warm reset
`timescale 1ns/100ps
module hlsc_device
	import hlsc_pkg::*;
#(
	parameter logic [15:0] FREQ_CAP = FREQ_CAP_DEFAULT
)(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// configuration access
	input  wire logic        cfg_sel,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_ack,
	// active link setup
	output logic [3:0]       active_freq_code,
	output logic [11:0]      active_freq_mhz,
	output logic             active_third_gen,
	output logic             active_rx_wide,
	output logic             active_tx_wide,
	output logic [9:0]       active_bias,
	output logic [1:0]       active_drive,
	output logic             link_active,
	// link
	hlsc_link_if.device      link
);
	import hlsc_pkg::*;

	localparam logic [2:0] READY_EDGES = 3'(LINK_READY_EDGES - 1);

	logic [6:0]  idx_index;
	logic        idx_we;
	logic [3:0]  freq_code;
	logic [2:0]  rx_width;
	logic [2:0]  tx_width;
	logic [9:0]  pll_bias;
	logic [1:0]  drive;
	logic        wr_hit;
	logic [31:0] next_rdata;
	logic [31:0] ind_rdata;
	logic        rst_s1;
	logic        rst_s2;
	logic        rst_s3;
	logic        lclk_s1;
	logic        lclk_s2;
	logic        lclk_s3;
	logic        warm_release;
	logic        lclk_rise;
	logic [2:0]  edge_cnt;

	// ****************************************
	// configuration writes
	// ****************************************
	assign wr_hit = cfg_sel & cfg_wr;

	// [R3] index and write enable
	// [R4] index register decode
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			idx_index <= 7'h00;
			idx_we    <= 1'b0;
		end else if (wr_hit && cfg_addr == OFF_INDIRECT_INDEX) begin
			idx_index <= cfg_wdata[IDX_MSB:IDX_LSB];
			idx_we    <= cfg_wdata[IDX_WE_BIT];
		end
	end

	// only sys_rst clears the programmed fields; a warm reset leaves them alone
	// [R14] survive warm reset
	// [R6] frequency code write
	// [R9] receive width write
	// [R10] transmit width write
	// [R8] bias write
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			freq_code <= FREQ_CODE_BOOT;
			rx_width  <= WIDTH_CODE_8;
			tx_width  <= WIDTH_CODE_8;
			pll_bias  <= BIAS_RESET;
		end else if (wr_hit) begin
			case (cfg_addr)
				OFF_LINK_FREQ: begin
					freq_code <= cfg_wdata[FREQ_MSB:FREQ_LSB];
				end
				OFF_LINK_WIDTH: begin
					rx_width <= cfg_wdata[RX_WIDTH_MSB:RX_WIDTH_LSB];
					tx_width <= cfg_wdata[TX_WIDTH_MSB:TX_WIDTH_LSB];
				end
				OFF_PLL_BIAS: begin
					pll_bias <= cfg_wdata[BIAS_MSB:BIAS_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	// a data write without the enable flag is dropped silently
	// [R3] gated indirect write
	// [R11] drive strength entry
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			drive <= DRIVE_RESET;
		end else if (wr_hit && cfg_addr == OFF_INDIRECT_DATA && idx_we && idx_index == IDX_DRIVE_STRENGTH) begin
			drive <= cfg_wdata[DRIVE_MSB:DRIVE_LSB];
		end
	end

	// ****************************************
	// configuration reads
	// ****************************************
	// [R3] indexed entry read
	always_comb begin
		ind_rdata = 32'h0000_0000;
		if (idx_index == IDX_DRIVE_STRENGTH) begin
			ind_rdata[DRIVE_MSB:DRIVE_LSB] = drive;
		end
	end

	// [R5] read-only capability
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (cfg_addr)
			OFF_INDIRECT_INDEX: begin
				next_rdata[IDX_MSB:IDX_LSB] = idx_index;
				next_rdata[IDX_WE_BIT]      = idx_we;
			end
			OFF_INDIRECT_DATA: begin
				next_rdata = ind_rdata;
			end
			OFF_LINK_WIDTH: begin
				next_rdata[RX_WIDTH_MSB:RX_WIDTH_LSB] = rx_width;
				next_rdata[TX_WIDTH_MSB:TX_WIDTH_LSB] = tx_width;
			end
			OFF_LINK_FREQ: begin
				next_rdata[CAP_MSB:CAP_LSB]   = FREQ_CAP;
				next_rdata[FREQ_MSB:FREQ_LSB] = freq_code;
			end
			OFF_PLL_BIAS: begin
				next_rdata[BIAS_MSB:BIAS_LSB] = pll_bias;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_ack   <= 1'b0;
		end else begin
			cfg_ack   <= cfg_sel;
			cfg_rdata <= (cfg_sel && !cfg_wr) ? next_rdata : 32'h0000_0000;
		end
	end

	// ****************************************
	// link input synchronisers
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rst_s1  <= 1'b0;
			rst_s2  <= 1'b0;
			rst_s3  <= 1'b0;
			lclk_s1 <= 1'b0;
			lclk_s2 <= 1'b0;
			lclk_s3 <= 1'b0;
		end else begin
			rst_s1  <= link.link_reset;
			rst_s2  <= rst_s1;
			rst_s3  <= rst_s2;
			lclk_s1 <= link.link_clk;
			lclk_s2 <= lclk_s1;
			lclk_s3 <= lclk_s2;
		end
	end

	assign warm_release = rst_s3 & ~rst_s2;
	assign lclk_rise    = lclk_s2 & ~lclk_s3;

	// ****************************************
	// active link setup
	// ****************************************
	// power-up forces the slow narrow link whatever the fields hold
	// [R1] boot at 200 MHz, 8 bits
	// [R2] load only on warm release
	// [R12] code shown to far end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			active_freq_code   <= FREQ_CODE_BOOT;
			active_rx_wide     <= 1'b0;
			active_tx_wide     <= 1'b0;
			active_bias        <= BIAS_RESET;
			active_drive       <= DRIVE_RESET;
			link.dev_freq_code <= FREQ_CODE_BOOT;
		end else if (warm_release) begin
			active_freq_code   <= freq_code;
			active_rx_wide     <= (rx_width == WIDTH_CODE_16);
			active_tx_wide     <= (tx_width == WIDTH_CODE_16);
			active_bias        <= pll_bias;
			active_drive       <= drive;
			link.dev_freq_code <= freq_code;
		end
	end

	// undefined codes show zero MHz and first generation
	// [R7] code to rate and generation
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			active_freq_mhz  <= hlsc_code_mhz(FREQ_CODE_BOOT);
			active_third_gen <= 1'b0;
		end else begin
			active_freq_mhz  <= hlsc_code_mhz(active_freq_code);
			active_third_gen <= (active_freq_code > FREQ_CODE_GEN1_MAX) && (active_freq_code <= FREQ_CODE_MAX);
		end
	end

	// ****************************************
	// link ready
	// ****************************************
	// the link is declared up after a few clean link clock edges out of reset
	// [R13] sole device on the chain
	always_ff @(posedge clock) begin
		if (sys_rst || rst_s2) begin
			edge_cnt       <= 3'h0;
			link_active    <= 1'b0;
			link.dev_ready <= 1'b0;
		end else if (lclk_rise && !link_active) begin
			if (edge_cnt == READY_EDGES) begin
				link_active    <= 1'b1;
				link.dev_ready <= 1'b1;
			end else begin
				edge_cnt <= edge_cnt + 3'h1;
			end
		end
	end

endmodule

// file: design/hlsc_pkg.sv
// constants and helpers shared by both ends of the host link speed configuration
package hlsc_pkg;

	// ****************************************
	// configuration space offsets
	// ****************************************
	localparam logic [7:0] OFF_INDIRECT_INDEX = 8'h94;
	localparam logic [7:0] OFF_INDIRECT_DATA  = 8'h98;
	localparam logic [7:0] OFF_LINK_WIDTH     = 8'hc8;
	localparam logic [7:0] OFF_LINK_FREQ      = 8'hd0;
	localparam logic [7:0] OFF_PLL_BIAS       = 8'hd8;
	localparam logic [6:0] IDX_DRIVE_STRENGTH = 7'h2a;

	// ****************************************
	// field positions
	// ****************************************
	localparam int IDX_WE_BIT     = 8;
	localparam int IDX_LSB        = 0;
	localparam int IDX_MSB        = 6;
	localparam int CAP_LSB        = 16;
	localparam int CAP_MSB        = 31;
	localparam int FREQ_LSB       = 8;
	localparam int FREQ_MSB       = 11;
	localparam int RX_WIDTH_LSB   = 24;
	localparam int RX_WIDTH_MSB   = 26;
	localparam int TX_WIDTH_LSB   = 28;
	localparam int TX_WIDTH_MSB   = 30;
	localparam int BIAS_LSB       = 0;
	localparam int BIAS_MSB       = 9;
	localparam int DRIVE_LSB      = 0;
	localparam int DRIVE_MSB      = 1;

	// ****************************************
	// reset values and encodings
	// ****************************************
	localparam logic [3:0]  FREQ_CODE_BOOT   = 4'h0;
	localparam logic [3:0]  FREQ_CODE_GEN1_MAX = 4'h6;
	localparam logic [3:0]  FREQ_CODE_MAX    = 4'he;
	localparam logic [2:0]  WIDTH_CODE_8     = 3'h0;
	localparam logic [2:0]  WIDTH_CODE_16    = 3'h1;
	localparam logic [9:0]  BIAS_RESET       = 10'h000;
	localparam logic [1:0]  DRIVE_RESET      = 2'h0;
	localparam logic [15:0] FREQ_CAP_DEFAULT = 16'h7ff5;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLOCK_MHZ          = 250;
	localparam int LINK_HALF_NS       = 40;
	localparam int LINK_HALF_CYCLES   = (LINK_HALF_NS * CLOCK_MHZ) / 1000;
	localparam int WARM_RESET_NS      = 400;
	localparam int WARM_RESET_CYCLES  = (WARM_RESET_NS * CLOCK_MHZ + 999) / 1000;
	localparam int LINK_READY_EDGES   = 4;

	// frequency of a code in MHz, zero for an undefined code
	function automatic logic [11:0] hlsc_code_mhz(input logic [3:0] code);
		logic [11:0] mhz;
		mhz = 12'h000;
		case (code)
			4'h0: mhz = 12'd200;
			4'h2: mhz = 12'd400;
			4'h4: mhz = 12'd600;
			4'h5: mhz = 12'd800;
			4'h6: mhz = 12'd1000;
			4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he: mhz = 12'((code - 4'h7) * 200 + 1200);
			default: mhz = 12'h000;
		endcase
		return mhz;
	endfunction

endpackage

// file: design/hlsc_link_if.sv
// link between the bridge device end and the processor end
`timescale 1ns/100ps
interface hlsc_link_if;
	logic       link_clk;
	logic       link_reset;
	logic       dev_ready;
	logic [3:0] dev_freq_code;

	modport device (
		input  link_clk,
		input  link_reset,
		output dev_ready,
		output dev_freq_code
	);

	modport processor (
		output link_clk,
		output link_reset,
		input  dev_ready,
		input  dev_freq_code
	);
endinterface

// file: design/hlsc_processor.sv
// processor end: makes the link clock, drives warm reset, holds its own speed settings
`timescale 1ns/100ps
module hlsc_processor
	import hlsc_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// user side
	input  wire logic        set_valid,
	input  wire logic [3:0]  set_freq_code,
	input  wire logic [2:0]  set_rx_width,
	input  wire logic [2:0]  set_tx_width,
	input  wire logic        warm_req,
	output logic [15:0]      proc_freq_cap,
	output logic [3:0]       active_freq_code,
	output logic             active_rx_wide,
	output logic             active_tx_wide,
	output logic             link_up,
	output logic             freq_mismatch,
	// link
	hlsc_link_if.processor   link
);
	import hlsc_pkg::*;

	localparam logic [15:0] HALF_CNT = 16'(LINK_HALF_CYCLES - 1);
	localparam logic [15:0] WARM_CNT = 16'(WARM_RESET_CYCLES - 1);

	logic [3:0]  pend_freq;
	logic [2:0]  pend_rx;
	logic [2:0]  pend_tx;
	logic [15:0] div_cnt;
	logic [15:0] warm_cnt;
	logic        in_warm;
	logic        ready_s1;
	logic        ready_s2;
	logic [3:0]  code_s1;
	logic [3:0]  code_s2;

	// ****************************************
	// pending settings, kept through warm reset
	// ****************************************
	// [R2] stage, not apply
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pend_freq <= FREQ_CODE_BOOT;
			pend_rx   <= WIDTH_CODE_8;
			pend_tx   <= WIDTH_CODE_8;
		end else if (set_valid) begin
			pend_freq <= set_freq_code;
			pend_rx   <= set_rx_width;
			pend_tx   <= set_tx_width;
		end
	end

	// ****************************************
	// warm reset sequence
	// ****************************************
	// [R2] apply at release
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			in_warm          <= 1'b0;
			warm_cnt         <= 16'h0000;
			link.link_reset  <= 1'b0;
			active_freq_code <= FREQ_CODE_BOOT;
			active_rx_wide   <= 1'b0;
			active_tx_wide   <= 1'b0;
		end else if (!in_warm) begin
			if (warm_req) begin
				in_warm         <= 1'b1;
				warm_cnt        <= WARM_CNT;
				link.link_reset <= 1'b1;
			end
		end else if (warm_cnt != 16'h0000) begin
			warm_cnt <= warm_cnt - 16'h0001;
		end else begin
			in_warm          <= 1'b0;
			link.link_reset  <= 1'b0;
			active_freq_code <= pend_freq;
			active_rx_wide   <= (pend_rx == WIDTH_CODE_16);
			active_tx_wide   <= (pend_tx == WIDTH_CODE_16);
		end
	end

	// ****************************************
	// link clock divider
	// ****************************************
	// the link clock is a modelled stand-in: fixed rate, whatever the active code
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_cnt       <= 16'h0000;
			link.link_clk <= 1'b0;
		end else if (div_cnt == HALF_CNT) begin
			div_cnt       <= 16'h0000;
			link.link_clk <= ~link.link_clk;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// ****************************************
	// device status
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ready_s1 <= 1'b0;
			ready_s2 <= 1'b0;
			code_s1  <= FREQ_CODE_BOOT;
			code_s2  <= FREQ_CODE_BOOT;
		end else begin
			ready_s1 <= link.dev_ready;
			ready_s2 <= ready_s1;
			code_s1  <= link.dev_freq_code;
			code_s2  <= code_s1;
		end
	end

	// [R13] one device, unit 0
	// [R12] codes must agree
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			link_up       <= 1'b0;
			freq_mismatch <= 1'b0;
			proc_freq_cap <= FREQ_CAP_DEFAULT;
		end else begin
			link_up       <= ready_s2 & ~in_warm;
			freq_mismatch <= ready_s2 & ~in_warm & (code_s2 != active_freq_code);
			proc_freq_cap <= FREQ_CAP_DEFAULT;
		end
	end

endmodule

// file: verification/hlsc_link_monitor.sv
// concurrent checks on the link between the device end and the processor end
`timescale 1ns/100ps
module hlsc_link_monitor (
	// clock and reset
	input wire logic       clock,
	input wire logic       sys_rst,
	// link
	input wire logic       link_clk,
	input wire logic       link_reset,
	input wire logic       dev_ready,
	input wire logic [3:0] dev_freq_code
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// ****************************************
	// helper state
	// ****************************************
	logic       lclk_q;
	logic       seen_warm;
	logic [3:0] rises;
	logic [7:0] since_fall;

	always_ff @(posedge clock) begin
		lclk_q <= sys_rst ? 1'b0 : link_clk;
	end

	always_ff @(posedge clock) begin
		seen_warm <= sys_rst ? 1'b0 : (seen_warm | link_reset);
	end

	// counted two stages ahead of the device's own sync, so the bound is safe
	always_ff @(posedge clock) begin
		if (sys_rst || link_reset) begin
			rises <= 4'h0;
		end else if (link_clk && !lclk_q && rises != 4'hf) begin
			rises <= rises + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || link_reset) begin
			since_fall <= 8'h00;
		end else if (since_fall != 8'hff) begin
			since_fall <= since_fall + 8'h01;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	chk_boot_code: assert property (!seen_warm |-> dev_freq_code == 4'h0)
		else $error("frequency code left boot value without warm reset");
	chk_ready_boot: assert property ($fell(sys_rst) |-> !dev_ready [*8])
		else $error("ready too early after power-up");
	chk_code_when: assert property ($changed(dev_freq_code) |-> since_fall >= 8'h01 && since_fall <= 8'h08)
		else $error("frequency code changed outside warm reset release");
	chk_code_hold: assert property (link_reset |=> $stable(dev_freq_code))
		else $error("frequency code moved during warm reset");
	chk_ready_drop: assert property (link_reset [*5] |-> !dev_ready)
		else $error("ready kept through warm reset");
	chk_ready_bound: assert property ($fell(link_reset) |-> ##[1:300] dev_ready)
		else $error("link did not restart after warm reset");
	chk_ready_hold: assert property (dev_ready && !link_reset |=> dev_ready)
		else $error("running link dropped without warm reset");
	chk_ready_edges: assert property ($rose(dev_ready) |-> rises >= 4'h4 && !$changed(dev_freq_code))
		else $error("ready before four link clock edges");
endmodule

// file: verification/tb_host_link_speed_config.sv
// self-checking bench joining the device end and the processor end
`timescale 1ns/100ps
module tb_host_link_speed_config;
	import hlsc_pkg::*;
	logic        clock, sys_rst, cfg_sel, cfg_wr, cfg_ack, set_valid, warm_req;
	logic [7:0]  cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, q;
	logic [3:0]  d_code, p_code, c;
	logic [11:0] d_mhz;
	logic        d_gen3, d_rxw, d_txw, d_active, p_rxw, p_txw, link_up, freq_mismatch;
	logic [9:0]  d_bias;
	logic [1:0]  d_drive;
	logic [3:0]  set_freq_code;
	logic [2:0]  set_rx_width, set_tx_width;
	logic [15:0] proc_freq_cap;
	int          fails, checks;

	hlsc_link_if hlsc_link_if_i ();

	hlsc_device hlsc_device_i (.clock(clock), .sys_rst(sys_rst), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
		.active_freq_code(d_code), .active_freq_mhz(d_mhz), .active_third_gen(d_gen3),
		.active_rx_wide(d_rxw), .active_tx_wide(d_txw), .active_bias(d_bias), .active_drive(d_drive),
		.link_active(d_active), .link(hlsc_link_if_i.device));

	hlsc_processor hlsc_processor_i (.clock(clock), .sys_rst(sys_rst), .set_valid(set_valid),
		.set_freq_code(set_freq_code), .set_rx_width(set_rx_width), .set_tx_width(set_tx_width),
		.warm_req(warm_req), .proc_freq_cap(proc_freq_cap), .active_freq_code(p_code),
		.active_rx_wide(p_rxw), .active_tx_wide(p_txw), .link_up(link_up),
		.freq_mismatch(freq_mismatch), .link(hlsc_link_if_i.processor));

	hlsc_link_monitor hlsc_link_monitor_i (.clock(clock), .sys_rst(sys_rst),
		.link_clk(hlsc_link_if_i.link_clk), .link_reset(hlsc_link_if_i.link_reset),
		.dev_ready(hlsc_link_if_i.dev_ready), .dev_freq_code(hlsc_link_if_i.dev_freq_code));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ****************************************
	// tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task tick;
		@(posedge clock);
		#1;
	endtask

	// one access: strobe for a single cycle, answer one cycle later
	task cfg(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		cfg_sel = 1'b1;
		cfg_wr = wr;
		cfg_addr = a;
		cfg_wdata = d;
		tick();
		// ack and read data stand for this one cycle only
		check(32'(cfg_ack), 32'h1);
		r = cfg_rdata;
		cfg_sel = 1'b0;
		tick();
	endtask

	function automatic logic [11:0] exp_mhz(input logic [3:0] k);
		case (k)
			4'h0: return 12'd200;
			4'h2: return 12'd400;
			4'h4: return 12'd600;
			4'h5: return 12'd800;
			4'h6: return 12'd1000;
			4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he: return 12'(12'd1200 + 12'(k - 4'h7) * 12'd200);
			default: return 12'h000;
		endcase
	endfunction

	// program both ends, then restart the link through a warm reset
	task warm(input logic [3:0] dc, input logic [3:0] pc, input logic [2:0] w);
		logic [7:0] was;
		was = {d_code, p_code};
		cfg(1'b1, OFF_LINK_FREQ, {20'h0, dc, 8'h00}, q);
		cfg(1'b1, OFF_LINK_WIDTH, {1'b0, w, 1'b0, w, 24'h0}, q);
		set_valid = 1'b1;
		set_freq_code = pc;
		set_rx_width = w;
		set_tx_width = w;
		tick();
		set_valid = 1'b0;
		check(32'({d_code, p_code}), 32'(was));
		warm_req = 1'b1;
		tick();
		warm_req = 1'b0;
		for (int n = 0; n < 20 && hlsc_link_if_i.link_reset !== 1'b1; n++) tick();
		for (int n = 0; n < 200 && hlsc_link_if_i.link_reset !== 1'b0; n++) tick();
		for (int n = 0; n < 400 && link_up !== 1'b1; n++) tick();
		repeat (4) tick();
		check(32'(link_up), 32'h1);
		check(32'(d_code), 32'(dc));
		check(32'(d_mhz), 32'(exp_mhz(dc)));
		check(32'(d_gen3), 32'(dc > FREQ_CODE_GEN1_MAX && dc <= FREQ_CODE_MAX));
		check(32'({d_rxw, d_txw}), {30'h0, {2{w == 3'h1}}});
		check(32'({p_rxw, p_txw}), {30'h0, {2{w == 3'h1}}});
		check(32'(p_code), 32'(pc));
		check(32'(hlsc_link_if_i.dev_freq_code), 32'(dc));
		check(32'(freq_mismatch), 32'(dc != pc));
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		{sys_rst, cfg_sel, cfg_wr, cfg_addr, cfg_wdata, set_valid, warm_req} = '0;
		{set_freq_code, set_rx_width, set_tx_width} = '0;
		fails = 0;
		checks = 0;
		sys_rst = 1'b1;
		repeat (2) @(posedge clock);
		#1 sys_rst = 1'b0;
		check({d_mhz, d_code, d_rxw, d_txw}, {12'h0, 12'd200, 4'h0, 2'b00});
		check(32'(proc_freq_cap), 32'(FREQ_CAP_DEFAULT));
		cfg(1'b0, OFF_LINK_FREQ, 32'h0, q);
		check({q[31:16], 4'h0, q[11:8]}, {FREQ_CAP_DEFAULT, 8'h00});
		for (int n = 0; n < 400 && link_up !== 1'b1; n++) tick();
		check(32'(link_up), 32'h1);
		cfg(1'b1, OFF_LINK_FREQ, 32'hffff_0900, q);
		cfg(1'b0, OFF_LINK_FREQ, 32'h0, q);
		check({q[31:16], 4'h0, q[11:8]}, {FREQ_CAP_DEFAULT, 8'h09});
		check(32'(d_code), 32'h0);
		cfg(1'b1, OFF_PLL_BIAS, 32'h0000_03ff, q);
		cfg(1'b0, OFF_PLL_BIAS, 32'h0, q);
		check(32'(q[9:0]), 32'h3ff);
		cfg(1'b1, OFF_PLL_BIAS, 32'h0000_0096, q);
		// indirect entry: data write without the enable flag must not land
		cfg(1'b1, OFF_INDIRECT_INDEX, 32'h0000_002a, q);
		cfg(1'b1, OFF_INDIRECT_DATA, 32'h0000_0003, q);
		cfg(1'b0, OFF_INDIRECT_DATA, 32'h0, q);
		check(32'(q[1:0]), 32'h0);
		cfg(1'b1, OFF_INDIRECT_INDEX, 32'h0000_012a, q);
		cfg(1'b1, OFF_INDIRECT_DATA, 32'h0000_0003, q);
		cfg(1'b0, OFF_INDIRECT_DATA, 32'h0, q);
		check(32'(q[1:0]), 32'h3);
		cfg(1'b0, OFF_INDIRECT_INDEX, 32'h0, q);
		check(32'({q[8], q[6:0]}), 32'h0aa);
		cfg(1'b1, OFF_INDIRECT_INDEX, 32'h0000_012b, q);
		cfg(1'b0, OFF_INDIRECT_DATA, 32'h0, q);
		check(q, 32'h0);
		cfg(1'b1, 8'h40, 32'hffff_ffff, q);
		cfg(1'b0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		for (int k = 0; k <= 14; k++) begin
			c = 4'(k);
			if (FREQ_CAP_DEFAULT[k]) begin
				warm(c, c, {2'b00, ~c[0]});
			end
		end
		check({22'h0, d_bias}, 32'h096);
		check(32'({d_drive, d_active}), 32'h7);
		cfg(1'b0, OFF_PLL_BIAS, 32'h0, q);
		check(32'(q[9:0]), 32'h096);
		// undefined code and unsupported width value: zero rate, first generation, 8 bits
		warm(4'hf, 4'hf, 3'h2);
		warm(4'h7, 4'h9, 3'h1);
		end_of_test();
	end

	initial begin
		#60000;
		fails++;
		end_of_test();
	end
endmodule
